// *** rtl/trtc_pkg.sv ***
// trtc_pkg: register map, field layout and timing constants of the timekeeper
// assumes a byte-addressed Avalon-MM slave, one aligned word per register
package trtc_pkg;
	localparam logic [15:0] ADDR_IRQ_CTL = 16'hFF94;
	localparam logic [15:0] ADDR_CTL = 16'hFFB0;
	localparam logic [15:0] ADDR_CNT0 = 16'hFFB4;
	localparam logic [15:0] ADDR_CNT1 = 16'hFFB8;
	localparam logic [15:0] ADDR_CNT2 = 16'hFFBC;
	localparam logic [15:0] ADDR_CNT3 = 16'hFFC0;
	localparam logic [15:0] ADDR_ACC0 = 16'hFFC4;
	localparam logic [15:0] ADDR_ACC1 = 16'hFFC8;
	localparam logic [15:0] ADDR_ACC2 = 16'hFFCC;
	localparam logic [15:0] ADDR_TRIM0 = 16'hFFD0;
	localparam logic [15:0] ADDR_TRIM1 = 16'hFFD4;
	localparam logic [15:0] ADDR_TRIM2 = 16'hFFD8;
	localparam logic [15:0] ADDR_CLKSRC = 16'hFFDC;

	// interrupt control fields
	localparam int IRQ_EN_BIT = 5;
	localparam int IRQ_FLAG_BIT = 4;
	// control fields, then the clock source enable bit
	localparam int LOAD_BIT = 5;
	localparam int TSEL_HI = 4;
	localparam int TSEL_LO = 3;
	localparam int IVL_HI = 2;
	localparam int IVL_LO = 0;
	localparam int OSC_EN_BIT = 0;

	localparam logic [7:0] IRQ_CTL_RESET = 8'h00;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic OSC_EN_RESET = 1'b1;

	localparam int CNT_W = 32;
	localparam int ACC_W = 24;
	localparam int TRIM_SIGN = 23;

	// timing: 32768 Hz clock, half-second mark
	localparam int TK_FREQ_HZ = 32768;
	localparam int HALF_SEC_MS = 500;
	localparam int HALF_SEC_TICKS_DEF = TK_FREQ_HZ * HALF_SEC_MS / 1000;
	localparam int MCLK_DIV_DEF = 2930;
	localparam int CLK_FREQ_HZ = 10000000;

	// tick masks over the free-running half-second mark counter
	localparam logic [3:0] MASK_HALF = 4'h0;
	localparam logic [3:0] MASK_1S = 4'h1;
	localparam logic [3:0] MASK_2S = 4'h3;
	localparam logic [3:0] MASK_4S = 4'h7;
	localparam logic [3:0] MASK_8S = 4'hF;

	localparam logic [1:0] TSEL_HALF = 2'h2;
	localparam logic [1:0] TSEL_2S = 2'h3;
	localparam logic [2:0] IVL_HALF = 3'h4;
	localparam logic [2:0] IVL_2S = 3'h5;
	localparam logic [2:0] IVL_4S = 3'h6;
	localparam logic [2:0] IVL_8S = 3'h7;

	typedef enum logic [1:0] {
		TRTC_BUS_IDLE,
		TRTC_BUS_ACK
	} trtc_bus_t;
endpackage : trtc_pkg

// *** rtl/trtc_top.sv ***
// trtc_top: real-time clock with trim accumulator, periodic interrupt and watchdog
// assumes X32K is synchronous to CLK and an Avalon-MM master with waitrequest
`timescale 1ns/10ps

module trtc_top import trtc_pkg::*; #(
	parameter int HALF_SEC_TICKS = HALF_SEC_TICKS_DEF,
	parameter int MCLK_DIV = MCLK_DIV_DEF
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic X32K,
	input wire logic [15:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic EXT_INT5,
	output logic CHIP_RESET
);
	localparam int DIV_W = $clog2(MCLK_DIV + 1);
	localparam int HS_W = $clog2(HALF_SEC_TICKS + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MCLK_DIV - 1);
	localparam logic [HS_W-1:0] HS_LAST = HS_W'(HALF_SEC_TICKS - 1);

	trtc_bus_t bus_state;
	logic [7:0] stage [0:9];
	logic irq_en;
	logic irq_flag;
	logic [7:0] ctl;
	logic osc_en;
	logic x32k_d;
	logic [DIV_W-1:0] div_cnt;
	logic tk_edge;
	logic [HS_W-1:0] hs_cnt;
	logic half_mark;
	logic [3:0] mark_cnt;
	logic [CNT_W-1:0] counter;
	logic [ACC_W-1:0] accum;
	logic [ACC_W-1:0] trim;
	logic [HS_W-1:0] wd_cnt;
	logic req;
	logic commit_wr;
	logic commit_rd;
	logic [3:0] tick_mask;
	logic [3:0] ivl_mask;
	logic count_tick;
	logic irq_event;
	logic [ACC_W:0] next_sum;
	logic overflow;
	logic load_now;
	logic service;
	logic flag_read;
	logic [7:0] next_rdata;
	logic [CNT_W-1:0] next_counter;
	logic [31:0] stage_cnt;
	logic [ACC_W-1:0] stage_acc;
	logic [ACC_W-1:0] stage_trim;

	assign req = AVS_READ | AVS_WRITE;
	assign commit_wr = AVS_WRITE & (bus_state == TRTC_BUS_ACK);
	assign commit_rd = AVS_READ & (bus_state == TRTC_BUS_ACK);

	// bus handshake: one wait state, access commits at the edge waitrequest is low
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			bus_state <= TRTC_BUS_IDLE;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			case (bus_state)
				TRTC_BUS_IDLE: begin
					if (req) begin
						bus_state <= TRTC_BUS_ACK;
						AVS_WAITREQUEST <= 1'b0;
					end
				end
				TRTC_BUS_ACK: begin
					bus_state <= TRTC_BUS_IDLE;
					AVS_WAITREQUEST <= 1'b1;
				end
				default: begin
					bus_state <= TRTC_BUS_IDLE;
					AVS_WAITREQUEST <= 1'b1;
				end
			endcase
		end
	end

	// read mux: count, accumulator and trim bytes show the live timekeeping values
	always_comb begin
		next_rdata = 8'h00;
		case (AVS_ADDRESS)
			ADDR_IRQ_CTL: begin
				next_rdata[IRQ_EN_BIT] = irq_en;
				next_rdata[IRQ_FLAG_BIT] = irq_flag;
			end
			ADDR_CTL: next_rdata = ctl;
			ADDR_CNT0: next_rdata = counter[7:0];
			ADDR_CNT1: next_rdata = counter[15:8];
			ADDR_CNT2: next_rdata = counter[23:16];
			ADDR_CNT3: next_rdata = counter[31:24];
			ADDR_ACC0: next_rdata = accum[7:0];
			ADDR_ACC1: next_rdata = accum[15:8];
			ADDR_ACC2: next_rdata = accum[23:16];
			ADDR_TRIM0: next_rdata = trim[7:0];
			ADDR_TRIM1: next_rdata = trim[15:8];
			ADDR_TRIM2: next_rdata = trim[23:16];
			ADDR_CLKSRC: next_rdata[OSC_EN_BIT] = osc_en;
			default: next_rdata = 8'h00;
		endcase
	end

	// snapshot taken when the request is accepted, held through the commit edge
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ && bus_state == TRTC_BUS_IDLE) begin
			AVS_READDATA <= {24'h00_0000, next_rdata};
		end
	end

	// staging bytes, low byte first: count 0..3, accumulator 4..6, trim 7..9
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_stage
			always_ff @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					stage[gi] <= 8'h00;
				end else if (commit_wr && AVS_BYTEENABLE[0] &&
					AVS_ADDRESS == ADDR_CNT0 + 16'(4 * gi)) begin
					stage[gi] <= AVS_WRITEDATA[7:0];
				end
			end
		end
	endgenerate

	assign stage_cnt = {stage[3], stage[2], stage[1], stage[0]};
	assign stage_acc = {stage[6], stage[5], stage[4]};
	assign stage_trim = {stage[9], stage[8], stage[7]};

	// control register; the load bit clears itself once the load is done
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctl <= CTL_RESET;
		end else begin
			if (load_now) begin
				ctl[LOAD_BIT] <= 1'b0;
			end
			if (commit_wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == ADDR_CTL) begin
				ctl <= {2'b00, AVS_WRITEDATA[5:0]};
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			osc_en <= OSC_EN_RESET;
		end else if (commit_wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == ADDR_CLKSRC) begin
			osc_en <= AVS_WRITEDATA[OSC_EN_BIT];
		end
	end

	// timekeeping clock: crystal rising edge, or master clock divided
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			x32k_d <= 1'b0;
			div_cnt <= '0;
		end else begin
			x32k_d <= X32K;
			if (div_cnt == DIV_LAST || osc_en) begin
				div_cnt <= '0;
			end else begin
				div_cnt <= div_cnt + DIV_W'(1);
			end
		end
	end

	assign tk_edge = osc_en ? (X32K & ~x32k_d) : (div_cnt == DIV_LAST);

	// half-second marks
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			hs_cnt <= '0;
			mark_cnt <= 4'h0;
		end else if (tk_edge) begin
			if (hs_cnt == HS_LAST) begin
				hs_cnt <= '0;
				mark_cnt <= mark_cnt + 4'h1;
			end else begin
				hs_cnt <= hs_cnt + HS_W'(1);
			end
		end
	end

	assign half_mark = tk_edge & (hs_cnt == HS_LAST);

	always_comb begin
		case (ctl[TSEL_HI:TSEL_LO])
			TSEL_HALF: tick_mask = MASK_HALF;
			TSEL_2S: tick_mask = MASK_2S;
			default: tick_mask = MASK_1S;
		endcase
		case (ctl[IVL_HI:IVL_LO])
			IVL_HALF: ivl_mask = MASK_HALF;
			IVL_2S: ivl_mask = MASK_2S;
			IVL_4S: ivl_mask = MASK_4S;
			IVL_8S: ivl_mask = MASK_8S;
			default: ivl_mask = MASK_1S;
		endcase
	end

	assign count_tick = half_mark & ((mark_cnt & tick_mask) == tick_mask);
	assign irq_event = half_mark & ((mark_cnt & ivl_mask) == ivl_mask);
	assign load_now = tk_edge & ctl[LOAD_BIT];

	assign next_sum = {1'b0, accum} + {2'b00, trim[TRIM_SIGN-1:0]};
	assign overflow = next_sum[ACC_W];

	always_comb begin
		next_counter = counter + 32'h0000_0001;
		if (overflow && !trim[TRIM_SIGN]) begin
			next_counter = counter + 32'h0000_0002;
		end else if (overflow && trim[TRIM_SIGN]) begin
			next_counter = counter;
		end
	end

	// timekeeping state; a load takes priority over a tick on the same edge
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			counter <= '0;
			accum <= '0;
			trim <= '0;
		end else if (load_now) begin
			counter <= stage_cnt;
			accum <= stage_acc;
			trim <= stage_trim;
		end else if (count_tick) begin
			counter <= next_counter;
			accum <= next_sum[ACC_W-1:0];
		end
	end

	// clear only a flag this read returned, so an event landing on the snapshot survives
	assign flag_read = commit_rd & (AVS_ADDRESS == ADDR_IRQ_CTL)
		& AVS_READDATA[IRQ_FLAG_BIT];
	assign service = flag_read;

	// interrupt control: enable is software owned, flag set by event wins over read-clear
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_en <= IRQ_CTL_RESET[IRQ_EN_BIT];
			irq_flag <= IRQ_CTL_RESET[IRQ_FLAG_BIT];
		end else begin
			if (commit_wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == ADDR_IRQ_CTL) begin
				irq_en <= AVS_WRITEDATA[IRQ_EN_BIT];
			end
			if (irq_event) begin
				irq_flag <= 1'b1;
			end else if (flag_read) begin
				irq_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			EXT_INT5 <= 1'b0;
		end else begin
			EXT_INT5 <= irq_flag & irq_en;
		end
	end

	// watchdog: counts timekeeping ticks while an enabled interrupt waits for service
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wd_cnt <= '0;
			CHIP_RESET <= 1'b0;
		end else begin
			CHIP_RESET <= 1'b0;
			if (!irq_en || !irq_flag || service) begin
				wd_cnt <= '0;
			end else if (tk_edge) begin
				if (wd_cnt == HS_LAST) begin
					wd_cnt <= '0;
					CHIP_RESET <= 1'b1;
				end else begin
					wd_cnt <= wd_cnt + HS_W'(1);
				end
			end
		end
	end

	// checks
	wait_one_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(req && AVS_WAITREQUEST && bus_state == TRTC_BUS_IDLE) |=> !AVS_WAITREQUEST)
		else $error("waitrequest not released after one cycle");
	irq_and_a: assert property (@(posedge CLK) disable iff (!RSTN)
		EXT_INT5 == $past(irq_flag & irq_en))
		else $error("interrupt output not flag and enable");
	flag_set_a: assert property (@(posedge CLK) disable iff (!RSTN)
		irq_event |=> irq_flag)
		else $error("flag not set by periodic event");
	flag_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(flag_read && !irq_event) |=> !irq_flag)
		else $error("flag not cleared by read");
	load_copy_a: assert property (@(posedge CLK) disable iff (!RSTN)
		load_now |=> (counter == $past(stage_cnt) && trim == $past(stage_trim)
			&& !ctl[LOAD_BIT]))
		else $error("load did not transfer staged values");
	tick_pos_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(count_tick && !load_now && overflow && !trim[TRIM_SIGN]) |=>
			counter == $past(counter) + 32'h0000_0002)
		else $error("positive trim overflow did not add a count");
	tick_neg_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(count_tick && !load_now && overflow && trim[TRIM_SIGN]) |=> $stable(counter))
		else $error("negative trim overflow did not skip a count");
	wd_idle_a: assert property (@(posedge CLK) disable iff (!RSTN)
		!irq_en |=> (wd_cnt == '0 && !CHIP_RESET))
		else $error("watchdog active while disabled");
	wd_fire_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(tk_edge && irq_en && irq_flag && !service && wd_cnt == HS_LAST) |=> CHIP_RESET)
		else $error("watchdog did not fire at half a second");
	mark_rate_a: assert property (@(posedge CLK) disable iff (!RSTN)
		half_mark |=> (hs_cnt == '0 && mark_cnt == $past(mark_cnt) + 4'h1))
		else $error("half-second mark at wrong count");
	acc_add_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(count_tick && !load_now) |=>
			accum == ACC_W'($past(accum) + {1'b0, $past(trim[TRIM_SIGN-1:0])}))
		else $error("accumulator not advanced by trim");

	// read snapshot, service restart, divider wrap and enable gating
	flag_keep_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(commit_rd && AVS_ADDRESS == ADDR_IRQ_CTL && irq_flag
			&& !AVS_READDATA[IRQ_FLAG_BIT]) |=> irq_flag)
		else $error("unread flag lost on register read");
	wd_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
		service |=> wd_cnt == '0)
		else $error("service did not restart watchdog window");
	tick_plain_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(count_tick && !load_now && !overflow) |=> counter == $past(counter) + 32'h0000_0001)
		else $error("counter did not advance by one on tick");
	div_wrap_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(tk_edge && !osc_en) |=> div_cnt == '0)
		else $error("master clock divider did not wrap");
	rdata_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(bus_state == TRTC_BUS_ACK) |=> $stable(AVS_READDATA))
		else $error("read data changed during acknowledge");
	irq_off_a: assert property (@(posedge CLK) disable iff (!RSTN)
		!irq_en |=> !EXT_INT5)
		else $error("interrupt output high while disabled");

	load_seen_c: cover property (@(posedge CLK) disable iff (!RSTN) load_now);
	irq_seen_c: cover property (@(posedge CLK) disable iff (!RSTN) EXT_INT5);
	wd_seen_c: cover property (@(posedge CLK) disable iff (!RSTN) CHIP_RESET);
	svc_seen_c: cover property (@(posedge CLK) disable iff (!RSTN) service);
	skip_seen_c: cover property (@(posedge CLK) disable iff (!RSTN)
		count_tick && overflow && trim[TRIM_SIGN]);
endmodule : trtc_top

// *** verif/test_trtc_top.sv ***
// test_trtc_top: self-checking bench for the timekeeper
// assumes trtc_core_model as bus master; X32K made here, synchronous to CLK
`timescale 1ns/10ps
module test_trtc_top import trtc_pkg::*; ;
	logic CLK, RSTN, X32K, rd_req, wr_req, hung, wait_req, int5, crst;
	logic [15:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	logic [15:0] lfsr = 16'h0028;
	int bad_count = 0;
	int n_compared = 0;
	int pulses = 0;
	int ivl_n[8] = '{8, 8, 8, 8, 16, 4, 2, 1};
	trtc_core_model core (.clk(CLK), .address(addr), .read(rd_req), .write(wr_req),
		.writedata(wdata), .byteenable(be), .readdata(rdata), .waitrequest(wait_req),
		.hung(hung));
	trtc_top #(.HALF_SEC_TICKS(4), .MCLK_DIV(3)) DUT (.CLK(CLK), .RSTN(RSTN), .X32K(X32K),
		.AVS_ADDRESS(addr), .AVS_READ(rd_req), .AVS_WRITE(wr_req), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
		.EXT_INT5(int5), .CHIP_RESET(crst));
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	always @(posedge CLK) if (crst === 1'b1) pulses <= pulses + 1;
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	always @(posedge hung) begin
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (100000) @(posedge CLK);
		bad_count++;
		stop_test();
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd
	// expected {trim, acc, count} after n ticks
	function automatic logic [79:0] run_ticks(input logic [79:0] v, input int n);
		logic [24:0] s;
		logic [31:0] c;
		logic [23:0] a, t;
		{t, a, c} = v;
		for (int i = 0; i < n; i++) begin
			s = {1'b0, a} + {2'b00, t[22:0]};
			a = s[23:0];
			c = c + (s[24] ? (t[23] ? 32'h00000000 : 32'h00000002) : 32'h00000001);
		end
		return {t, a, c};
	endfunction : run_ticks
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] m = 4'hF);
		logic [7:0] q;
		core.access(1'b0, a, d, m, q);
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] q);
		core.access(1'b1, a, 8'h00, 4'hF, q);
	endtask : rd
	// ten byte registers from count byte 0 up to trim byte 2, stride 4
	task automatic stage(input logic [79:0] v);
		for (int b = 0; b < 10; b++) wr(ADDR_CNT0 + 16'(4 * b), v[8 * b +: 8]);
	endtask : stage
	task automatic live(output logic [79:0] v);
		for (int b = 0; b < 10; b++) rd(ADDR_CNT0 + 16'(4 * b), v[8 * b +: 8]);
	endtask : live
	task automatic x_edges(input int n);
		repeat (n) begin
			@(posedge CLK);
			X32K <= 1'b1;
			repeat (2) @(posedge CLK);
			X32K <= 1'b0;
			repeat (4) @(posedge CLK);
		end
	endtask : x_edges
	initial begin
		logic [79:0] v, got;
		logic [31:0] cnt;
		logic [7:0] q, q2;
		logic e;
		int n, p0;
		RSTN = 1'b0;
		X32K = 1'b0;
		repeat (4) @(posedge CLK);
		RSTN <= 1'b1;
		rd(ADDR_IRQ_CTL, q);
		check("irq_ctl reset", q, IRQ_CTL_RESET);
		rd(ADDR_CTL, q);
		check("ctl reset", q, CTL_RESET);
		rd(ADDR_CLKSRC, q);
		check("clksrc reset", q, 8'h01);
		rd(16'h0000, q);
		check("unmapped", q, 8'h00);
		check("int5 reset", int5, 1'b0);
		for (int k = 0; k < 4; k++) begin
			cnt = {rnd(), rnd()};
			case (k)
				0: v = {8'h00, rnd(), 24'h000000, cnt};
				1: v = {24'h000001, 24'hFFFFFF, cnt};
				2: v = {24'h800001, 24'hFFFFFF, cnt};
				default: v = {8'h80, rnd(), 8'h00, rnd(), cnt};
			endcase
			stage(v);
			wr(ADDR_CTL, {2'b00, 1'b1, 2'(k), 3'b000});
			x_edges(1);
			rd(ADDR_CTL, q);
			check("load clears", q, {3'b000, 2'(k), 3'b000});
			live(got);
			check("loaded cnt", got[31:0], v[31:0]);
			check("loaded acc", got[55:32], v[55:32]);
			check("loaded trim", got[79:56], v[79:56]);
			x_edges(32);
			v = run_ticks(v, (k < 2) ? 4 : ((k == 2) ? 8 : 2));
			live(got);
			check("ticked cnt", got[31:0], v[31:0]);
			check("ticked acc", got[55:32], v[55:32]);
		end
		wr(ADDR_CTL, 8'h3F, 4'hE);
		rd(ADDR_CTL, q);
		check("be0 low ignored", q, 8'h18);
		wr(ADDR_IRQ_CTL, 8'h20);
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_CTL, 8'(c));
			rd(ADDR_IRQ_CTL, q);
			n = 0;
			repeat (64) begin
				x_edges(1);
				e = int5;
				rd(ADDR_IRQ_CTL, q);
				check("int5 vs flag", e, q[4]);
				check("irq_ctl en", q & 8'hEF, 8'h20);
				n += (q[4] === 1'b1);
			end
			check("events", n, ivl_n[c]);
		end
		check("serviced no reset", pulses, 0);
		wr(ADDR_CTL, {5'h00, IVL_HALF});
		p0 = pulses;
		x_edges(12);
		check("int5 pending", int5, 1'b1);
		check("watchdog fired", (pulses - p0) inside {[1:3]}, 1'b1);
		wr(ADDR_IRQ_CTL, 8'h00);
		repeat (2) @(posedge CLK);
		check("int5 masked", int5, 1'b0);
		p0 = pulses;
		x_edges(12);
		check("watchdog off", pulses, p0);
		wr(ADDR_CLKSRC, 8'h00);
		stage({24'h0006FD, 24'h000000, 32'h00000000});
		wr(ADDR_CTL, 8'h20);
		repeat (8) @(posedge CLK);
		rd(ADDR_CTL, q);
		check("mclk load", q, 8'h00);
		rd(ADDR_CNT0, q);
		repeat (480) @(posedge CLK);
		rd(ADDR_CNT0, q2);
		check("mclk rate", 8'(q2 - q) inside {[19:21]}, 1'b1);
		stop_test();
	end
endmodule : test_trtc_top

// *** verif/trtc_core_model.sv ***
// trtc_core_model: processor core side, byte-wide register reads and writes
// assumes an Avalon-MM slave with waitrequest clocked by clk
`timescale 1ns/10ps
module trtc_core_model (
	input wire logic clk,
	output logic [15:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	output logic hung
);
	initial begin
		address = 16'h0000;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		byteenable = 4'h0;
		hung = 1'b0;
	end
	task automatic access(input logic rd, input logic [15:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		read <= rd;
		write <= !rd;
		writedata <= {24'h000000, d};
		byteenable <= be;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (waitrequest !== 1'b0) begin
			hung <= 1'b1;
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		// released lines show a changed pattern
		address <= ~a;
		writedata <= {24'hFFFFFF, ~d};
	endtask : access
endmodule : trtc_core_model
